// ==== logic/pprh_keeper.sv ====
// weak pin keeper: remembers the last externally driven level of each pin
// assumes pin_driven tells when some driver other than the keeper holds the pin
`timescale 1ns/1ps
`include "pprh_params.svh"

module pprh_keeper #(
	parameter int WIDTH = `PPRH_NUM_CELLS
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	input wire logic [WIDTH-1:0] pin_driven,
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] kept
);

	logic [WIDTH-1:0] kept_reg;
	logic [WIDTH-1:0] kept_next;

	// any real driver overrides the keeper; it never stops, not even in sleep
	always_comb begin
		kept_next = kept_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (pin_driven[i]) begin
				kept_next[i] = pin_in[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kept_reg <= '0;
		end else begin
			kept_reg <= kept_next;
		end
	end

	// the array sees the driven level, else the remembered one
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			level[i] = pin_driven[i] ? pin_in[i] : kept_reg[i];
		end
	end

	assign kept = kept_reg;

endmodule // pprh_keeper

// ==== logic/pprh_params.svh ====
// constants for the power, reset and hold control block
// assumes a single 20 MHz clock; included by the block's design files
`ifndef PPRH_PARAMS_SVH
`define PPRH_PARAMS_SVH

`define PPRH_CLK_PERIOD_NS 50
// longest power-up clear time in ns
`define PPRH_POWERUP_CLEAR_TIME_NS 1000
// a longest time rounds down to whole cycles, never under one
`define PPRH_CLEAR_CYC ((`PPRH_POWERUP_CLEAR_TIME_NS / `PPRH_CLK_PERIOD_NS) < 1 ? 1 : \
	(`PPRH_POWERUP_CLEAR_TIME_NS / `PPRH_CLK_PERIOD_NS))
`define PPRH_NUM_CELLS 10
`define PPRH_SIG_BITS 64
`define PPRH_CELL_RESET 1'b0
`define PPRH_SIG_RESET 64'h0000_0000_0000_0000

`endif

// ==== logic/pprh_pkg.sv ====
// types shared by the power, reset and hold control block
// no assumptions beyond the params header for widths
`include "pprh_params.svh"

package pprh_pkg;

	// clear runs first, then normal operation, with sleep entered by pin
	typedef enum logic [1:0] {
		PPRH_CLEARING,
		PPRH_RUNNING,
		PPRH_SLEEPING
	} pprh_state_t;

	// status seen by the outside
	typedef struct packed {
		logic clearing;
		logic sleeping;
		logic secured;
		logic sleep_enabled;
	} pprh_status_t;

	// answer group for verify and preload requests
	typedef struct packed {
		logic verify_valid;
		logic refused;
	} pprh_answer_t;

endpackage

// ==== logic/pprh_top.sv ====
// housekeeping logic of a small registered logic device: power-up clear,
// preload, signature word, security lock, pin keepers and pin sleep mode
// assumes rst_n comes from the power-up detector and all inputs are synchronous to clk
//
// How it works
// - after power-up detect, all cells clear low within the clear time
// - pins show cleared cells through the configured output polarity
// - preload forces each cell to a chosen high or low value
// - the 64-bit signature stays writable and readable even when locked
// - with the lock fuse set, verify and preload are refused
// - undriven pins keep their last driven level; real drivers override
// - sleep pin high with sleep enabled freezes cells, logic and outputs
// - outputs undefined at sleep entry keep that same state
// - pin keepers stay active during sleep
// - with sleep enabled, the shared pin never feeds the array
// - sleep enable is a configuration bit loaded at power-up
// - with sleep disabled, the shared pin is an ordinary array input
`timescale 1ns/1ps
`include "pprh_params.svh"

module pprh_top #(
	parameter int N = `PPRH_NUM_CELLS,
	parameter int SIG_W = `PPRH_SIG_BITS,
	parameter int CLEAR_CYC = `PPRH_CLEAR_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cfg_sleep_en,
	input wire logic [N-1:0] cfg_out_pol,
	input wire logic lock_fuse,
	input wire logic shared_input_sleep_pin,
	input wire logic cell_clk_pin,
	input wire logic [N-1:0] cell_d,
	input wire logic [N-1:0] cell_oe,
	input wire logic [N-1:0] io_in,
	input wire logic [N-1:0] io_ext_drv,
	input wire logic preload_req,
	input wire logic [N-1:0] preload_data,
	input wire logic verify_req,
	input wire logic sig_wr,
	input wire logic [SIG_W-1:0] sig_wr_data,
	input wire logic sig_rd,
	output logic [N-1:0] cell_q,
	output logic [N-1:0] io_out,
	output logic [N-1:0] io_oe,
	output logic [N-1:0] array_in,
	output logic shared_array_in,
	output logic [N-1:0] keep_level,
	output logic [N-1:0] verify_data,
	output pprh_pkg::pprh_answer_t answer,
	output logic [SIG_W-1:0] sig_rd_data,
	output logic sig_rd_valid,
	output pprh_pkg::pprh_status_t status
);

	localparam int CNT_W = $clog2(CLEAR_CYC + 1);
	localparam logic [CNT_W-1:0] CLR_LAST = CNT_W'(CLEAR_CYC - 1);
	localparam int CLR_MAX = CLEAR_CYC + 1;

	// output pin level from a cell value and its buffer polarity (1 = true)
	function automatic logic [N-1:0] pin_of(input logic [N-1:0] q, input logic [N-1:0] pol);
		pin_of = ~(q ^ pol);
	endfunction

	pprh_pkg::pprh_state_t state_reg, state_next;
	logic [CNT_W-1:0] clr_cnt_reg, clr_cnt_next;
	logic sleep_en_reg, sleep_en_next;
	logic clk_prev_reg, clk_prev_next;
	logic [N-1:0] cell_reg, cell_next;
	logic [N-1:0] pin_reg, pin_next;
	logic [N-1:0] oe_reg, oe_next;
	logic [N-1:0] arr_reg, arr_next;
	logic shared_reg, shared_next;
	logic [N-1:0] vdata_reg, vdata_next;
	pprh_pkg::pprh_answer_t ans_reg, ans_next;
	logic [SIG_W-1:0] sig_reg, sig_next;
	logic [SIG_W-1:0] sig_out_reg, sig_out_next;
	logic sig_vld_reg, sig_vld_next;
	logic [N-1:0] kp_level;
	logic [N-1:0] kp_kept;
	logic sleep_now;
	logic clk_rise;

	// keepers see our own drive as a driver too
	pprh_keeper #(
		.WIDTH(N)
	) u_keeper (
		.clk(clk),
		.rst_n(rst_n),
		.pin_in(io_in),
		.pin_driven(io_ext_drv | oe_reg),
		.level(kp_level),
		.kept(kp_kept)
	);

	// level sensitive; ignored until the clear is over
	assign sleep_now = sleep_en_reg && shared_input_sleep_pin && (state_reg != pprh_pkg::PPRH_CLEARING);
	assign clk_rise = cell_clk_pin && !clk_prev_reg;

	// sequencing: clear after power-up, then run and sleep by pin level
	always_comb begin
		state_next = state_reg;
		clr_cnt_next = clr_cnt_reg;
		sleep_en_next = sleep_en_reg;
		unique case (state_reg)
			pprh_pkg::PPRH_CLEARING: begin
				clr_cnt_next = clr_cnt_reg + CNT_W'(1);
				if (clr_cnt_reg == CLR_LAST) begin
					state_next = pprh_pkg::PPRH_RUNNING;
				end
			end
			pprh_pkg::PPRH_RUNNING: begin
				if (sleep_now) begin
					state_next = pprh_pkg::PPRH_SLEEPING;
				end
			end
			pprh_pkg::PPRH_SLEEPING: begin
				if (!sleep_now) begin
					state_next = pprh_pkg::PPRH_RUNNING;
				end
			end
		endcase
	end

	// the sleep enable fuse is captured while the detector holds reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= pprh_pkg::PPRH_CLEARING;
			clr_cnt_reg <= '0;
			sleep_en_reg <= cfg_sleep_en;
		end else begin
			state_reg <= state_next;
			clr_cnt_reg <= clr_cnt_next;
			sleep_en_reg <= sleep_en_next;
		end
	end

	// macrocells and pins; sleep freezes everything, the clock included,
	// so an undefined output simply keeps whatever it held
	always_comb begin
		cell_next = cell_reg;
		pin_next = pin_reg;
		oe_next = oe_reg;
		arr_next = arr_reg;
		shared_next = shared_reg;
		clk_prev_next = clk_prev_reg;
		if (state_reg == pprh_pkg::PPRH_CLEARING) begin
			cell_next = {N{`PPRH_CELL_RESET}};
			clk_prev_next = cell_clk_pin;
		end else if (!sleep_now) begin
			clk_prev_next = cell_clk_pin;
			if (preload_req && !lock_fuse) begin
				cell_next = preload_data;
			end else if (clk_rise) begin
				cell_next = cell_d;
			end
			oe_next = cell_oe;
			arr_next = kp_level;
			// shared pin feeds the array only when sleep is disabled
			shared_next = sleep_en_reg ? 1'b0 : shared_input_sleep_pin;
		end else begin
			// the clock level stays held, so an edge seen in sleep fires at wake if the pin is still high
			clk_prev_next = clk_prev_reg;
		end
		if (!sleep_now) begin
			pin_next = pin_of(cell_next, cfg_out_pol);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cell_reg <= {N{`PPRH_CELL_RESET}};
			pin_reg <= pin_of({N{`PPRH_CELL_RESET}}, cfg_out_pol);
			oe_reg <= '0;
			arr_reg <= '0;
			shared_reg <= 1'b0;
			clk_prev_reg <= 1'b1;
		end else begin
			cell_reg <= cell_next;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
			arr_reg <= arr_next;
			shared_reg <= shared_next;
			clk_prev_reg <= clk_prev_next;
		end
	end

	// verify, preload refusal and signature; lock takes effect at once
	always_comb begin
		vdata_next = vdata_reg;
		ans_next = '0;
		sig_next = sig_reg;
		sig_out_next = sig_out_reg;
		sig_vld_next = 1'b0;
		// the wake cycle is live for the cells, so requests are taken there too
		if (state_reg != pprh_pkg::PPRH_CLEARING && !sleep_now) begin
			if (verify_req) begin
				if (lock_fuse) begin
					ans_next.refused = 1'b1;
				end else begin
					ans_next.verify_valid = 1'b1;
					vdata_next = cfg_out_pol;
				end
			end
			if (preload_req && lock_fuse) begin
				ans_next.refused = 1'b1;
			end
			// signature ignores the lock
			if (sig_wr) begin
				sig_next = sig_wr_data;
			end
			if (sig_rd) begin
				sig_out_next = sig_reg;
				sig_vld_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			vdata_reg <= '0;
			ans_reg <= '0;
			sig_reg <= `PPRH_SIG_RESET;
			sig_out_reg <= '0;
			sig_vld_reg <= 1'b0;
		end else begin
			vdata_reg <= vdata_next;
			ans_reg <= ans_next;
			sig_reg <= sig_next;
			sig_out_reg <= sig_out_next;
			sig_vld_reg <= sig_vld_next;
		end
	end

	assign cell_q = cell_reg;
	assign io_out = pin_reg;
	assign io_oe = oe_reg;
	assign array_in = arr_reg;
	assign shared_array_in = shared_reg;
	assign keep_level = kp_kept;
	assign verify_data = vdata_reg;
	assign answer = ans_reg;
	assign sig_rd_data = sig_out_reg;
	assign sig_rd_valid = sig_vld_reg;
	// clearing and sleeping are decoded from the state flop; secured is the refused bit of the answer flop, sleep_enabled comes from its own flop
	assign status.clearing = (state_reg == pprh_pkg::PPRH_CLEARING);
	assign status.sleeping = (state_reg == pprh_pkg::PPRH_SLEEPING);
	assign status.secured = ans_reg.refused;
	assign status.sleep_enabled = sleep_en_reg;

	sequence s_released;
		$rose(rst_n);
	endsequence

	sequence s_sleep_pair;
		sleep_now ##1 sleep_now;
	endsequence

	sequence s_wake;
		sleep_now ##1 !sleep_now;
	endsequence

	a_clear_done: assert property (@(posedge clk) s_released |-> ##[1:CLR_MAX] !status.clearing)
		else $error("power-up clear did not finish in time");
	a_clear_low: assert property (@(posedge clk) disable iff (!rst_n)
		status.clearing |=> cell_reg == '0)
		else $error("cell not low during clear");
	a_pin_polarity: assert property (@(posedge clk) disable iff (!rst_n)
		!status.sleeping |-> io_out == pin_of(cell_reg, cfg_out_pol))
		else $error("pin level does not follow polarity");
	a_preload_force: assert property (@(posedge clk) disable iff (!rst_n)
		(!status.clearing && !sleep_now && preload_req && !lock_fuse)
		|=> cell_reg == $past(preload_data))
		else $error("preload did not force the cells");
	a_lock_refuse: assert property (@(posedge clk) disable iff (!rst_n)
		(status.clearing == 1'b0 && !sleep_now && (verify_req || preload_req) && lock_fuse)
		|=> answer.refused && !answer.verify_valid
		&& cell_reg == $past(clk_rise ? cell_d : cell_reg))
		else $error("locked device did not refuse");
	a_sig_read: assert property (@(posedge clk) disable iff (!rst_n)
		(!status.clearing && !sleep_now && sig_rd) |=> sig_rd_valid && sig_rd_data == $past(sig_reg))
		else $error("signature read failed");
	a_sleep_freeze: assert property (@(posedge clk) disable iff (!rst_n)
		s_sleep_pair |=> $stable(cell_reg) && $stable(io_out) && $stable(io_oe) && $stable(array_in))
		else $error("state moved during sleep");
	a_shared_block: assert property (@(posedge clk) disable iff (!rst_n)
		sleep_en_reg |=> !shared_array_in)
		else $error("shared pin reached the array");
	a_shared_input: assert property (@(posedge clk) disable iff (!rst_n)
		(!sleep_en_reg && !status.clearing) |=> shared_array_in == $past(shared_input_sleep_pin))
		else $error("shared pin not passed as input");
	a_wake_resume: assert property (@(posedge clk) disable iff (!rst_n)
		s_wake |-> ##1 !status.clearing && status.sleeping == 1'b0)
		else $error("wake did not resume normally");

endmodule // pprh_top

// ==== test/pprh_sys_model.sv ====
// model of the system logic: drives the cell clock and the sleep pin
// assumes the bench asks for clock pulses and sleep through clk_go and sleep_cmd
`timescale 1ns/1ps

module pprh_sys_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clearing,
	input wire logic clk_go,
	input wire logic sleep_cmd,
	output logic cell_clk_pin = 1'b0,
	output logic sleep_pin = 1'b0
);
	logic wake_wait_reg = 1'b0;

	// one short clock pulse per request; still while clearing and just after wake
	always @(posedge clk) begin
		sleep_pin <= sleep_cmd;
		wake_wait_reg <= sleep_pin & ~sleep_cmd;
		if (!rst_n || clearing) begin
			cell_clk_pin <= 1'b0;
		end else begin
			cell_clk_pin <= clk_go & ~cell_clk_pin & ~wake_wait_reg;
		end
	end
endmodule // pprh_sys_model

// ==== test/testbench.sv ====
// self-checking bench for the power, reset and hold control block
// assumes the system model drives the cell clock and the sleep pin
`timescale 1ns/1ps
`include "pprh_params.svh"

module testbench;
	localparam int N = `PPRH_NUM_CELLS;
	localparam int CLR = 3;
	localparam logic [N-1:0] POL = 10'h155;
	localparam logic [63:0] W1 = 64'hA5C3_0F1E_7788_1234;
	localparam logic [63:0] W2 = 64'h1111_2222_3333_4444;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic sleep_en = 1'b1;
	logic lock_fuse = 1'b0;
	logic clk_go = 1'b0;
	logic sleep_cmd = 1'b0;
	logic cell_clk_pin;
	logic sleep_pin;
	logic [N-1:0] cell_d = 10'h000;
	logic [N-1:0] cell_oe = 10'h000;
	logic [N-1:0] io_in = 10'h000;
	logic [N-1:0] io_ext_drv = 10'h3FF;
	logic [N-1:0] preload_data = 10'h000;
	logic [3:0] req = 4'h0;
	logic [63:0] sig_wr_data = 64'h0;
	logic [N-1:0] cell_q, io_out, io_oe, array_in, keep_level, verify_data;
	logic shared_array_in, sig_rd_valid;
	logic [63:0] sig_rd_data;
	pprh_pkg::pprh_answer_t answer;
	pprh_pkg::pprh_status_t status;
	int fail_count = 0;
	int cmp_count = 0;

	pprh_top #(.CLEAR_CYC(CLR)) i_pprh_top (
		.clk(clk), .rst_n(rst_n), .cfg_sleep_en(sleep_en), .cfg_out_pol(POL),
		.lock_fuse(lock_fuse), .shared_input_sleep_pin(sleep_pin),
		.cell_clk_pin(cell_clk_pin), .cell_d(cell_d), .cell_oe(cell_oe),
		.io_in(io_in), .io_ext_drv(io_ext_drv), .preload_req(req[0]),
		.preload_data(preload_data), .verify_req(req[1]), .sig_wr(req[2]),
		.sig_wr_data(sig_wr_data), .sig_rd(req[3]), .cell_q(cell_q), .io_out(io_out),
		.io_oe(io_oe), .array_in(array_in), .shared_array_in(shared_array_in),
		.keep_level(keep_level), .verify_data(verify_data), .answer(answer),
		.sig_rd_data(sig_rd_data), .sig_rd_valid(sig_rd_valid), .status(status)
	);

	pprh_sys_model i_pprh_sys_model (
		.clk(clk), .rst_n(rst_n), .clearing(status.clearing), .clk_go(clk_go),
		.sleep_cmd(sleep_cmd), .cell_clk_pin(cell_clk_pin), .sleep_pin(sleep_pin)
	);

	// 20 MHz clock
	initial begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// one-cycle request pulse; bits are read, write, verify, preload
	task automatic go(input logic [3:0] m, input logic [63:0] d);
		@(posedge clk);
		req <= m;
		preload_data <= d[N-1:0];
		sig_wr_data <= d;
		@(posedge clk);
		req <= 4'h0;
		#1;
	endtask

	// cell_d is set a full cycle before the model raises the clock, so setup holds
	task automatic t_clock(input logic [N-1:0] d, input logic [N-1:0] exp);
		@(posedge clk);
		cell_d <= d;
		clk_go <= 1'b1;
		@(posedge clk);
		clk_go <= 1'b0;
		@(posedge clk);
		#1;
		chk("cell_q", cell_q, exp);
		// cast keeps the inversion at pin width, not at the compare width
		chk("io_out", io_out, N'(~(exp ^ POL)));
	endtask

	task automatic t_reset(input logic en);
		int n;
		n = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		sleep_en <= en;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		while (status.clearing !== 1'b0 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("clear_len", 64'(n >= CLR - 1 && n <= CLR + 1), 64'h1);
		chk("cleared", cell_q, 10'h000);
		chk("pin_pol", io_out, N'(~POL));
		chk("sleep_en", status.sleep_enabled, en);
	endtask

	// undriven pins hold the last driven level
	task automatic t_keeper();
		@(posedge clk);
		io_in <= 10'h0F3;
		repeat (3) @(posedge clk);
		io_ext_drv <= 10'h000;
		io_in <= 10'h30C;
		repeat (3) @(posedge clk);
		#1;
		chk("kept", keep_level, 10'h0F3);
		chk("kept_arr", array_in, 10'h0F3);
		@(posedge clk);
		io_ext_drv <= 10'h3FF;
		cell_oe <= 10'h003;
	endtask

	task automatic t_lock();
		go(4'h1, 64'h30F);
		chk("preload", cell_q, 10'h30F);
		@(posedge clk);
		lock_fuse <= 1'b1;
		go(4'h1, 64'h0F0);
		chk("pre_refused", answer.refused, 1'b1);
		chk("locked_q", cell_q, 10'h30F);
		go(4'h2, 64'h0);
		chk("ver_refused", answer, 2'b01);
		@(posedge clk);
		lock_fuse <= 1'b0;
		go(4'h2, 64'h0);
		chk("ver_ok", answer, 2'b10);
		chk("ver_data", verify_data, POL);
	endtask

	task automatic t_sig();
		go(4'h4, W1);
		@(posedge clk);
		lock_fuse <= 1'b1;
		go(4'h8, 64'h0);
		chk("sig_valid", sig_rd_valid, 1'b1);
		chk("sig_data", sig_rd_data, W1);
		go(4'hC, W2);
		chk("sig_old", sig_rd_data, W1);
		go(4'h8, 64'h0);
		chk("sig_new", sig_rd_data, W2);
		@(posedge clk);
		lock_fuse <= 1'b0;
	endtask

	// clock, preload and pins are blocked in sleep; wake resumes the same state
	task automatic t_sleep();
		@(posedge clk);
		sleep_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("sleeping", status.sleeping, 1'b1);
		chk("shared_off", shared_array_in, 1'b0);
		// pins and enables move only once the freeze holds
		@(posedge clk);
		io_in <= 10'h3C0;
		cell_oe <= 10'h3FF;
		t_clock(10'h001, 10'h30F);
		go(4'h1, 64'h0AA);
		chk("no_answer", answer, 2'b00);
		chk("frozen_q", cell_q, 10'h30F);
		chk("frozen_arr", array_in, 10'h30C);
		chk("keep_live", keep_level, 10'h3C0);
		chk("frozen_oe", io_oe, 10'h003);
		@(posedge clk);
		sleep_cmd <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("awake", status.sleeping, 1'b0);
		chk("resumed", cell_q, 10'h30F);
		chk("oe_live", io_oe, 10'h3FF);
		t_clock(10'h0C3, 10'h0C3);
		chk("arr_live", array_in, 10'h3C0);
	endtask

	// sleep disabled: the shared pin is a plain array input
	task automatic t_shared();
		@(posedge clk);
		sleep_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("no_sleep", status.sleeping, 1'b0);
		chk("shared_hi", shared_array_in, 1'b1);
		t_clock(10'h2AA, 10'h2AA);
		@(posedge clk);
		sleep_cmd <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("shared_lo", shared_array_in, 1'b0);
	endtask

	initial begin
		t_reset(1'b1);
		t_clock(10'h2B6, 10'h2B6);
		t_keeper();
		t_lock();
		t_sig();
		t_sleep();
		t_reset(1'b0);
		t_shared();
		close_out();
	end

	// the sequence needs under a hundred cycles; this cuts a hang short
	initial begin
		#(3000 * 50);
		fail_count++;
		close_out();
	end
endmodule // testbench
